// >>> design/temp_sense_ctrl.sv
// Temperature sensor control and readout registers behind an APB slave
//
// What this block does
// - Result readable: bits 10..3 in one byte, bits 2..0 in bits 7..5 of next.
// - Result is an eleven-bit word everywhere it is used.
// - Read-only room-temperature reference, three high bits and eight low bits.
// - While a control-byte write commits, pending flag is one and control writes ignored.
// - With battery enable set, battery is measured with every temperature reading.
// - Battery select: one picks main battery, zero picks clock battery.
// - Three-bit period field runs automatic measurements; zero disables them.
// - With period zero, software may set one-shot bit for a single measurement.
// - Hardware clears the one-shot bit when that measurement has finished.
module temp_sense_ctrl #(
  parameter int unsigned COMMIT_LEN = temp_sense_pkg::COMMIT_CYCLES,
  parameter int unsigned SECOND_LEN = temp_sense_pkg::TICKS_PER_SECOND
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [temp_sense_pkg::ADDR_W-1:0] paddr,
  input wire logic [temp_sense_pkg::DATA_W-1:0] pwdata,
  output logic [temp_sense_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog sensor front end
  output logic meas_start,
  output logic meas_battery,
  output logic battery_select,
  input wire logic sensor_done,
  input wire logic [temp_sense_pkg::RESULT_W-1:0] sensor_reading,
  // Stored trim value for 22 C
  input wire logic [temp_sense_pkg::RESULT_W-1:0] room_ref_in
);
  import temp_sense_pkg::*;

  localparam int unsigned COMMIT_W = $clog2(COMMIT_LEN + 1);
  localparam int unsigned TICK_W = $clog2(SECOND_LEN + 1);
  localparam logic [COMMIT_W-1:0] COMMIT_LAST = COMMIT_W'(COMMIT_LEN - 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SECOND_LEN - 1);

  // Register state
  logic [PER_W-1:0] period_q;
  logic bat_en_q;
  logic bsel_q;
  logic [PER_W-1:0] stage_period_q;
  logic stage_bat_q;
  logic stage_bsel_q;
  logic pending_q;
  logic [COMMIT_W-1:0] commit_cnt_q;
  logic oneshot_q;
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] ref_meta_q;
  logic [RESULT_W-1:0] ref_q;
  logic [RESULT_W-1:0] reading_meta_q;
  logic [RESULT_W-1:0] reading_sync_q;
  logic [DATA_W-1:0] prdata_q;
  // Sequencer and timers
  meas_state_t state_q;
  meas_state_t state_d;
  logic start_q;
  logic meas_bat_q;
  logic done_meta_q;
  logic done_sync_q;
  logic done_prev_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic [SEC_W-1:0] sec_cnt_q;
  logic due_q;

  // Address decode
  wire logic hit_ref_high = (paddr == ADDR_REF_HIGH);
  wire logic hit_ref_low = (paddr == ADDR_REF_LOW);
  wire logic hit_res_high = (paddr == ADDR_RESULT_HIGH);
  wire logic hit_res_low = (paddr == ADDR_RESULT_LOW);
  wire logic hit_ctrl = (paddr == ADDR_CTRL);
  wire logic hit_oneshot = (paddr == ADDR_ONESHOT);
  wire logic addr_hit = hit_ref_high | hit_ref_low | hit_res_high | hit_res_low |
                        hit_ctrl | hit_oneshot;
  wire logic access = psel & penable;
  wire logic wr_ok = access & pwrite & addr_hit;
  wire logic rd_setup = psel & ~penable & ~pwrite;

  // Write strobes; control writes during a commit are dropped
  wire logic wr_ctrl = wr_ok & hit_ctrl & ~pending_q;
  wire logic wr_ctrl_locked = wr_ok & hit_ctrl & pending_q;
  wire logic wr_oneshot_set = wr_ok & hit_oneshot & pwdata[ONESHOT_BIT] &
                              (period_q == PER_OFF);
  wire logic commit_end = pending_q & (commit_cnt_q == '0);

  // Sequencer events
  wire logic done_pulse = done_sync_q & ~done_prev_q;
  wire logic meas_done = (state_q == ST_WAIT) & done_pulse;
  wire logic auto_on = (period_q != PER_OFF);
  wire logic cont_mode = (period_q == PER_CONTINUOUS);
  wire logic launch = (state_q == ST_IDLE) & (oneshot_q | (due_q & auto_on) | cont_mode);
  wire logic sec_tick = (tick_cnt_q == TICK_LAST);
  // Seconds between automatic runs for periods one to six: two to the power (3 + period)
  wire logic [SEC_W-1:0] period_secs = SEC_W'(1) << (PER_BASE_EXP + 32'(period_q));
  wire logic period_hit = auto_on & ~cont_mode & sec_tick & (sec_cnt_q + 1'b1 >= period_secs);

  // Read data assembly
  wire logic [7:0] ctrl_byte = {bsel_q, 2'b00, bat_en_q, pending_q, period_q};
  wire logic [7:0] res_low_byte = {result_q[RESULT_LOW_W-1:0], 5'b00000};
  wire logic [DATA_W-1:0] rd_mux =
      hit_ref_high ? DATA_W'(ref_q[RESULT_W-1:RESULT_W-REF_HIGH_W]) :
      hit_ref_low ? DATA_W'(ref_q[7:0]) :
      hit_res_high ? DATA_W'(result_q[RESULT_W-1:RESULT_LOW_W]) :
      hit_res_low ? DATA_W'(res_low_byte) :
      hit_ctrl ? DATA_W'(ctrl_byte) :
      hit_oneshot ? DATA_W'({oneshot_q, 6'b000000}) : '0;

  // Zero-wait slave; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access & ~addr_hit;
  assign prdata = prdata_q;
  assign meas_start = start_q;
  assign meas_battery = meas_bat_q;
  assign battery_select = bsel_q;

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (rd_setup) begin
      prdata_q <= rd_mux;
    end
  end

  // Staging of a control-byte write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_period_q <= PER_RESET;
      stage_bat_q <= 1'b0;
      stage_bsel_q <= 1'b0;
    end else if (wr_ctrl) begin
      stage_period_q <= pwdata[PER_LSB +: PER_W];
      stage_bat_q <= pwdata[BAT_BIT];
      stage_bsel_q <= pwdata[BSEL_BIT];
    end
  end

  // Commit timer; the slow write keeps the pending flag high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_q <= 1'b0;
      commit_cnt_q <= '0;
    end else if (wr_ctrl) begin
      pending_q <= 1'b1;
      commit_cnt_q <= COMMIT_LAST;
    end else if (commit_end) begin
      pending_q <= 1'b0;
    end else if (pending_q) begin
      commit_cnt_q <= commit_cnt_q - 1'b1;
    end
  end

  // Committed control fields only change when the commit finishes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_q <= PER_RESET;
      bat_en_q <= 1'b0;
      bsel_q <= 1'b0;
    end else if (commit_end) begin
      period_q <= stage_period_q;
      bat_en_q <= stage_bat_q;
      bsel_q <= stage_bsel_q;
    end
  end

  // One-shot request; a new set wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oneshot_q <= 1'b0;
    end else if (wr_oneshot_set) begin
      oneshot_q <= 1'b1;
    end else if (meas_done) begin
      oneshot_q <= 1'b0;
    end
  end

  // Seconds base for automatic runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
    end else if (sec_tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // Period counter; cleared and held at zero while automatic updates are off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt_q <= '0;
      due_q <= 1'b0;
    end else begin
      if (!auto_on || period_hit) begin
        sec_cnt_q <= '0;
      end else if (sec_tick) begin
        sec_cnt_q <= sec_cnt_q + 1'b1;
      end
      if (period_hit) begin
        due_q <= 1'b1;
      end else if (launch || !auto_on) begin
        due_q <= 1'b0;
      end
    end
  end

  // Done strobe from the analog side crosses two flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_meta_q <= 1'b0;
      done_sync_q <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      done_meta_q <= sensor_done;
      done_sync_q <= done_meta_q;
      done_prev_q <= done_sync_q;
    end
  end

  // Reading bus crosses two flops too; it settles before done rises, so both agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reading_meta_q <= RESULT_RESET;
      reading_sync_q <= RESULT_RESET;
    end else begin
      reading_meta_q <= sensor_reading;
      reading_sync_q <= reading_meta_q;
    end
  end

  // Trim value is quasi-static, but still passes two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_meta_q <= REF_RESET;
      ref_q <= REF_RESET;
    end else begin
      ref_meta_q <= room_ref_in;
      ref_q <= ref_meta_q;
    end
  end

  // Whole word captured at once so the two bytes never mix
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= RESULT_RESET;
    end else if (meas_done) begin
      result_q <= reading_sync_q;
    end
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (launch) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (done_pulse) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers; battery request rides with the start pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      start_q <= 1'b0;
      meas_bat_q <= 1'b0;
    end else begin
      state_q <= state_d;
      start_q <= launch;
      meas_bat_q <= launch & bat_en_q;
    end
  end

  // Locked-out writes leave the staged byte untouched
  AST_LOCKED_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl_locked |=> $stable(stage_period_q) && $stable(stage_bat_q) &&
      $stable(stage_bsel_q) && (pending_q || $past(commit_end)))
    else $error("control byte changed during commit");

  // A free write raises the flag and holds it for at least the first eight cycles of the commit
  AST_PENDING_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> pending_q [*8])
    else $error("pending flag dropped early");

  // Battery request tracks the enable at every start
  AST_BAT_WITH_START: assert property (@(posedge pclk) disable iff (!presetn)
    launch |=> meas_start && (meas_battery == $past(bat_en_q)))
    else $error("battery request wrong at start");

  // Battery select follows the staged value at commit end
  AST_BSEL_COMMIT: assert property (@(posedge pclk) disable iff (!presetn)
    commit_end |=> battery_select == $past(stage_bsel_q))
    else $error("battery select not committed");

  // Period zero and no one-shot: no measurement starts
  AST_PERIOD_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (period_q == PER_OFF) && !oneshot_q && (state_q == ST_IDLE) |=> !meas_start)
    else $error("automatic run while disabled");

  // One-shot set only while the period is zero
  AST_ONESHOT_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(oneshot_q) |-> $past(period_q) == PER_OFF)
    else $error("one-shot accepted with period set");

  // One-shot clears as its measurement ends
  AST_ONESHOT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    meas_done && !wr_oneshot_set |=> !oneshot_q)
    else $error("one-shot not cleared");

  // Result only moves on completion, holding in every other cycle
  AST_RESULT_ATOMIC: assert property (@(posedge pclk) disable iff (!presetn)
    !meas_done |=> $stable(result_q))
    else $error("result changed without completion");

  // High result byte reads bits 10..3
  AST_READ_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && hit_res_high |=> prdata == DATA_W'($past(result_q[RESULT_W-1:RESULT_LOW_W])))
    else $error("result high byte wrong");

  // Reference low byte reads the stored value
  AST_READ_REF: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && hit_ref_low |=> prdata == DATA_W'($past(ref_q[7:0])))
    else $error("reference low byte wrong");

endmodule

// >>> design/temp_sense_pkg.sv
// Constants, register map and states for the temperature sensor control block
package temp_sense_pkg;

  // Clock and timing
  localparam int unsigned CLK_FREQ_HZ = 20_000_000;
  localparam int unsigned HZ_PER_MHZ = 1_000_000;
  localparam int unsigned COMMIT_TIME_US = 6000;
  localparam int unsigned COMMIT_CYCLES = COMMIT_TIME_US * (CLK_FREQ_HZ / HZ_PER_MHZ);
  localparam int unsigned TICKS_PER_SECOND = CLK_FREQ_HZ;

  // Bus geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_REF_HIGH = 16'h230A;
  localparam logic [15:0] IDX_REF_LOW = 16'h230B;
  localparam logic [15:0] IDX_RESULT_HIGH = 16'h2881;
  localparam logic [15:0] IDX_RESULT_LOW = 16'h2882;
  localparam logic [15:0] IDX_CTRL = 16'h28A0;
  localparam logic [15:0] IDX_ONESHOT = 16'h28B4;
  localparam logic [15:0] ADDR_REF_HIGH = 16'(IDX_REF_HIGH * 4);
  localparam logic [15:0] ADDR_REF_LOW = 16'(IDX_REF_LOW * 4);
  localparam logic [15:0] ADDR_RESULT_HIGH = 16'(IDX_RESULT_HIGH * 4);
  localparam logic [15:0] ADDR_RESULT_LOW = 16'(IDX_RESULT_LOW * 4);
  localparam logic [15:0] ADDR_CTRL = 16'(IDX_CTRL * 4);
  localparam logic [15:0] ADDR_ONESHOT = 16'(IDX_ONESHOT * 4);

  // Result and reference layout
  localparam int unsigned RESULT_W = 11;
  localparam int unsigned RESULT_LOW_W = 3;
  localparam int unsigned RESULT_LOW_LSB = 5;
  localparam int unsigned REF_HIGH_W = 3;
  localparam logic [10:0] RESULT_RESET = 11'h000;
  localparam logic [10:0] REF_RESET = 11'h000;

  // Control byte fields
  localparam int unsigned PER_W = 3;
  localparam int unsigned PER_LSB = 0;
  localparam int unsigned PENDING_BIT = 3;
  localparam int unsigned BAT_BIT = 4;
  localparam int unsigned BSEL_BIT = 7;
  localparam int unsigned ONESHOT_BIT = 6;
  localparam logic [2:0] PER_OFF = 3'h0;
  localparam logic [2:0] PER_CONTINUOUS = 3'h7;
  localparam logic [2:0] PER_RESET = 3'h0;
  localparam int unsigned PER_BASE_EXP = 3;
  localparam int unsigned SEC_W = 10;

  // Measurement sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_START = 3'b010,
    ST_WAIT = 3'b100
  } meas_state_t;

endpackage

// >>> testbench/tb_temp_sense_ctrl.sv
// Self-checking testbench for the temperature sensor control block
module tb_temp_sense_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import temp_sense_pkg::*;

  // Short commit and second counts keep the run brief
  localparam int unsigned T_COMMIT = 20;
  localparam int unsigned T_SECOND = 10;

  typedef struct {
    logic w;
    logic [15:0] a;
    logic [31:0] d;
    logic [31:0] exp;
    logic er;
  } row_t;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 16'h0000;
  logic [DATA_W-1:0] pwdata = 32'h0000_0000;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic meas_start;
  logic meas_battery;
  logic battery_select;
  logic sensor_done = 1'b0;
  logic [RESULT_W-1:0] sensor_reading = 11'h000;
  logic [RESULT_W-1:0] room_ref_in = 11'h5A3;
  int err_count = 0;
  int total_checks = 0;
  int start_count = 0;
  logic start_bat = 1'b0;
  logic [31:0] rd;
  logic er;
  int c0;

  // Plain register accesses, including read-only and unmapped places
  row_t rows [8] = '{
    '{1'b1, ADDR_REF_LOW, 32'h0000_00FF, 32'h0, 1'b0},
    '{1'b1, 16'h0004, 32'h0000_00FF, 32'h0, 1'b1},
    '{1'b0, ADDR_REF_HIGH, 32'h0, 32'h0000_0005, 1'b0},
    '{1'b0, ADDR_REF_LOW, 32'h0, 32'h0000_00A3, 1'b0},
    '{1'b0, ADDR_RESULT_HIGH, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_RESULT_LOW, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b0, 16'h0004, 32'h0, 32'h0, 1'b1}
  };

  always #25 pclk = ~pclk;

  // Launch monitor; sampled mid-cycle where outputs are settled
  always @(negedge pclk) begin
    if (meas_start === 1'b1) begin
      start_count++;
      start_bat = meas_battery;
    end
  end

  temp_sense_ctrl #(.COMMIT_LEN(T_COMMIT), .SECOND_LEN(T_SECOND)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_start(meas_start), .meas_battery(meas_battery), .battery_select(battery_select),
    .sensor_done(sensor_done), .sensor_reading(sensor_reading), .room_ref_in(room_ref_in)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer; an idle edge first so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic erv);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      stop_test();
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Software side polls the pending flag, bounded
  task automatic wait_commit();
    logic [31:0] v;
    logic e;
    for (int i = 0; i < 60; i++) begin
      apb(1'b0, ADDR_CTRL, 32'h0, v, e);
      if (v[PENDING_BIT] === 1'b0) return;
    end
    err_count++;
    stop_test();
  endtask

  // Waits for a launch after the count taken before the triggering write
  task automatic wait_start(input int base, input int lim);
    for (int i = 0; i < lim && start_count == base; i++) @(negedge pclk);
    if (start_count == base) begin
      err_count++;
      stop_test();
    end
  endtask

  // Sensor answers: value stable before done rises and held after
  task automatic finish_meas(input logic [10:0] val);
    @(posedge pclk);
    sensor_reading <= val;
    repeat (2) @(posedge pclk);
    sensor_done <= 1'b1;
    repeat (4) @(posedge pclk);
    sensor_done <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
      if (!rows[i].w) check(rd, rows[i].exp, "read data");
      check(32'(er), 32'(rows[i].er), "error response");
    end
    // Control write, then a second write while it is still committing
    apb(1'b1, ADDR_CTRL, 32'h0000_0090, rd, er);
    apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
    check(rd, 32'h0000_0008, "pending with old fields");
    apb(1'b1, ADDR_CTRL, 32'h0000_0000, rd, er);
    wait_commit();
    apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
    check(rd, 32'h0000_0090, "committed control");
    check(32'(battery_select), 32'h1, "main battery chosen");
    // Single measurement with battery enable set
    c0 = start_count;
    apb(1'b1, ADDR_ONESHOT, 32'h0000_0040, rd, er);
    wait_start(c0, 20);
    check(32'(start_bat), 32'h1, "battery measured too");
    apb(1'b0, ADDR_ONESHOT, 32'h0, rd, er);
    check(rd, 32'h0000_0040, "one-shot still set");
    finish_meas(11'h6B5);
    apb(1'b0, ADDR_RESULT_HIGH, 32'h0, rd, er);
    check(rd, 32'h0000_00D6, "result upper bits");
    apb(1'b0, ADDR_RESULT_LOW, 32'h0, rd, er);
    check(rd, 32'h0000_00A0, "result lower bits");
    apb(1'b0, ADDR_ONESHOT, 32'h0, rd, er);
    check(rd, 32'h0, "one-shot cleared");
    // Period zero: no automatic launches
    c0 = start_count;
    repeat (100) @(posedge pclk);
    check(32'(start_count - c0), 32'h0, "no automatic launch");
    // Continuous mode, clock battery, no battery measurement
    c0 = start_count;
    apb(1'b1, ADDR_CTRL, 32'h0000_0007, rd, er);
    wait_commit();
    check(32'(battery_select), 32'h0, "clock battery chosen");
    wait_start(c0, 30);
    check(32'(start_bat), 32'h0, "battery not measured");
    apb(1'b1, ADDR_ONESHOT, 32'h0000_0040, rd, er);
    apb(1'b0, ADDR_ONESHOT, 32'h0, rd, er);
    check(rd, 32'h0, "one-shot refused");
    c0 = start_count;
    finish_meas(11'h123);
    repeat (30) @(posedge pclk);
    check(32'(start_count - c0), 32'h1, "next launch in continuous mode");
    // Reset in mid-run
    presetn <= 1'b0;
    @(negedge pclk);
    check(32'(battery_select), 32'h0, "select cleared by reset");
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
    check(rd, 32'h0, "control after reset");
    // Period one: a run every sixteen seconds of ten cycles, first near cycle 160
    apb(1'b1, ADDR_CTRL, 32'h0000_0001, rd, er);
    wait_commit();
    c0 = start_count;
    repeat (140) @(posedge pclk);
    check(32'(start_count - c0), 32'h0, "early periodic launch");
    wait_start(c0, 40);
    stop_test();
  end
endmodule
